// ---- verilog/slirq_router.v ----
// per-link interrupt flags, enables, lane-0 mismatch check and pin routing
//
// What this block does
// - mismatch check uses lane 0 configuration data only.
// - received configuration differing from programmed expected values raises mismatch.
// - all configuration octets, checksum included, take part in comparison.
// - enable bit 0 gates the mismatch interrupt, resets to 0.
// - primary flag register holds eight link event flags, reset 0.
// - secondary flag register bit 0 is mismatch; bits 7:1 read zero.
// - enables and flags exist per link; page select chooses the copy.
// - routing bit 0 steers request to pin a (0) or pin b (1).
// - primary enable register gates the eight event sources, reset 0.
// - checksum event compares transmitted and computed checksum, not programmed value.
`timescale 1ns/1ps
`default_nettype none
`include "slirq_defines.vh"
module slirq_router (
  input wire clk_sys,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [15:0] link_events,
  input wire [1:0] cfg_oct_valid,
  input wire [3:0] cfg_oct_index,
  input wire [15:0] cfg_oct_data,
  input wire [1:0] cfg_done,
  input wire [1:0] cks_sent_valid,
  input wire [15:0] cks_sent,
  input wire [15:0] cks_calc,
  output reg interrupt_pin_a,
  output reg interrupt_pin_b
);
  // link_events: 8 bits per link, bit order of the primary flag register
  // cfg_oct_*: one lane-0 octet stream per link, octet index 0..13
  reg link_page_reg;
  reg link_irq_pin_route_reg;
  // per-link registers live inside the link loop; flat buses, link n in slice n, gather them
  wire [15:0] enable_pri_all;
  wire [1:0] mismatch_enable_all;
  wire [15:0] flags_pri_all;
  wire [1:0] mismatch_flag_all;
  // copies seen through the current page, for the read decode
  wire [7:0] enable_pri_sel;
  wire mismatch_enable_sel;
  wire [7:0] flags_pri_sel;
  wire mismatch_flag_sel;
  wire any_req;
  reg [7:0] rdata_next;
  reg interrupt_pin_a_next;
  reg interrupt_pin_b_next;
  reg [7:0] cfg_expected_reg [0:13];
  wire [1:0] mismatch_pulse;
  wire [1:0] link_req;
  wire [3:0] exp_idx;
  wire in_cfg_range;
  wire [11:0] cfg_ofs;
  assign cfg_ofs = reg_addr - `SLIRQ_OFS_CFG_EXP_FIRST;
  assign in_cfg_range = (reg_addr >= `SLIRQ_OFS_CFG_EXP_FIRST) && (reg_addr <= `SLIRQ_OFS_CFG_EXP_LAST);
  assign exp_idx = cfg_ofs[3:0];
  // page select picks which link's copy the bus sees
  assign enable_pri_sel = link_page_reg ? enable_pri_all[15:8] : enable_pri_all[7:0];
  assign mismatch_enable_sel = link_page_reg ? mismatch_enable_all[1] : mismatch_enable_all[0];
  assign flags_pri_sel = link_page_reg ? flags_pri_all[15:8] : flags_pri_all[7:0];
  assign mismatch_flag_sel = link_page_reg ? mismatch_flag_all[1] : mismatch_flag_all[0];
  // any flag of any link keeps a request standing
  assign any_req = |link_req;
  ////////////////////////////////////////////////////////////////////////
  // global page select and pin route
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      link_page_reg <= `SLIRQ_RST_BIT;
      link_irq_pin_route_reg <= `SLIRQ_RST_BIT;
    end else if (reg_wr) begin
      if (reg_addr == `SLIRQ_OFS_LINK_PAGE)
        link_page_reg <= reg_wdata[`SLIRQ_BIT_LINK_PAGE];
      if (reg_addr == `SLIRQ_OFS_PIN_SELECT)
        link_irq_pin_route_reg <= reg_wdata[`SLIRQ_BIT_PIN_ROUTE];
    end
  end
  // expected configuration octets, shared by both links as programmed by software
  integer k;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      for (k = 0; k < `SLIRQ_CFG_OCTETS; k = k + 1)
        cfg_expected_reg[k] <= `SLIRQ_RST_BYTE;
    end else if (reg_wr && in_cfg_range) begin
      cfg_expected_reg[exp_idx] <= reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // per-link copies of enables and flags
  genvar g;
  generate
    for (g = 0; g < `SLIRQ_NUM_LINKS; g = g + 1) begin : gen_link
      wire sel;
      wire [7:0] ev;
      wire [7:0] ev_eff;
      wire cks_good_event;
      wire [7:0] w1c;
      wire w1c_mis;
      wire [3:0] oidx;
      reg [7:0] enable_pri_reg;
      reg config_mismatch_irq_enable_reg;
      reg [7:0] flags_pri_reg;
      reg [7:0] flags_pri_next;
      reg config_mismatch_flag_reg;
      reg config_mismatch_flag_next;
      assign sel = (link_page_reg == g);
      // checksum event: transmitted vs receiver-computed, never programmed octet 13
      assign cks_good_event = cks_sent_valid[g] && (cks_sent[8*g +: 8] == cks_calc[8*g +: 8]);
      assign ev = {link_events[8*g+7 : 8*g+3], cks_good_event, link_events[8*g+1 : 8*g]};
      assign ev_eff = ev & enable_pri_reg;
      assign w1c = (reg_wr && sel && reg_addr == `SLIRQ_OFS_FLAGS_PRI) ? reg_wdata : 8'h00;
      assign w1c_mis = reg_wr && sel && reg_addr == `SLIRQ_OFS_FLAGS_SEC && reg_wdata[`SLIRQ_BIT_MISMATCH];
      assign oidx = (cfg_oct_index < 4'hd) ? cfg_oct_index : 4'hd;
      // only the lane-0 stream of each link feeds the checker
      slirq_cfg_compare u_cmp (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .oct_valid(cfg_oct_valid[g]),
        .oct_index(cfg_oct_index),
        .oct_data(cfg_oct_data[8*g +: 8]),
        .exp_data(cfg_expected_reg[oidx]),
        .cfg_done(cfg_done[g]),
        .mismatch_pulse(mismatch_pulse[g])
      );
      // enables written only through the selected page
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          enable_pri_reg <= `SLIRQ_RST_BYTE;
          config_mismatch_irq_enable_reg <= `SLIRQ_RST_BIT;
        end else if (reg_wr && sel) begin
          if (reg_addr == `SLIRQ_OFS_ENABLE_PRI)
            enable_pri_reg <= reg_wdata;
          if (reg_addr == `SLIRQ_OFS_ENABLE_SEC)
            config_mismatch_irq_enable_reg <= reg_wdata[`SLIRQ_BIT_MISMATCH];
        end
      end
      // next flag values; the set term comes last so an event in the clearing cycle wins
      always @* begin
        flags_pri_next = (flags_pri_reg & ~w1c) | ev_eff;
        config_mismatch_flag_next = (config_mismatch_flag_reg & ~w1c_mis)
          | (mismatch_pulse[g] & config_mismatch_irq_enable_reg);
      end
      // sticky flags; enables gate only the setting, a standing flag is never masked
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          flags_pri_reg <= `SLIRQ_RST_BYTE;
          config_mismatch_flag_reg <= `SLIRQ_RST_BIT;
        end else begin
          flags_pri_reg <= flags_pri_next;
          config_mismatch_flag_reg <= config_mismatch_flag_next;
        end
      end
      // publish this link's copies on the flat buses
      assign enable_pri_all[8*g +: 8] = enable_pri_reg;
      assign mismatch_enable_all[g] = config_mismatch_irq_enable_reg;
      assign flags_pri_all[8*g +: 8] = flags_pri_reg;
      assign mismatch_flag_all[g] = config_mismatch_flag_reg;
      assign link_req[g] = (|flags_pri_reg) | config_mismatch_flag_reg;
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // route the combined request to one pin only; the other stays low
  always @* begin
    interrupt_pin_a_next = 1'b0;
    interrupt_pin_b_next = 1'b0;
    if (link_irq_pin_route_reg)
      interrupt_pin_b_next = any_req;
    else
      interrupt_pin_a_next = any_req;
  end
  // pins registered, so they follow the flags one cycle later and never glitch
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      interrupt_pin_a <= 1'b0;
      interrupt_pin_b <= 1'b0;
    end else begin
      interrupt_pin_a <= interrupt_pin_a_next;
      interrupt_pin_b <= interrupt_pin_b_next;
    end
  end
  // read decode; expected octets fall to the default arm, anything unmapped reads zero
  always @* begin
    rdata_next = `SLIRQ_RST_BYTE;
    case (reg_addr)
      `SLIRQ_OFS_LINK_PAGE: begin
        rdata_next = {7'h00, link_page_reg};
      end
      `SLIRQ_OFS_ENABLE_PRI: begin
        rdata_next = enable_pri_sel;
      end
      `SLIRQ_OFS_ENABLE_SEC: begin
        rdata_next = {7'h00, mismatch_enable_sel};
      end
      `SLIRQ_OFS_FLAGS_PRI: begin
        rdata_next = flags_pri_sel;
      end
      `SLIRQ_OFS_FLAGS_SEC: begin
        rdata_next = {7'h00, mismatch_flag_sel};
      end
      `SLIRQ_OFS_PIN_SELECT: begin
        rdata_next = {7'h00, link_irq_pin_route_reg};
      end
      default: begin
        if (in_cfg_range) begin
          rdata_next = cfg_expected_reg[exp_idx];
        end
      end
    endcase
  end
  // read data registered one cycle after the strobe and held until the next read
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= `SLIRQ_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ---- include/slirq_defines.vh ----
// register offsets, field positions, reset values for the link interrupt router
`ifndef SLIRQ_DEFINES_VH
`define SLIRQ_DEFINES_VH
`define SLIRQ_ADDR_W 12
`define SLIRQ_OFS_LINK_PAGE 12'h300
`define SLIRQ_OFS_CFG_EXP_FIRST 12'h450
`define SLIRQ_OFS_CFG_EXP_LAST 12'h45d
`define SLIRQ_OFS_ENABLE_PRI 12'h4b8
`define SLIRQ_OFS_ENABLE_SEC 12'h4b9
`define SLIRQ_OFS_FLAGS_PRI 12'h4ba
`define SLIRQ_OFS_FLAGS_SEC 12'h4bb
`define SLIRQ_OFS_PIN_SELECT 12'h4bc
`define SLIRQ_CFG_OCTETS 14
`define SLIRQ_NUM_LINKS 2
`define SLIRQ_BIT_MISMATCH 0
`define SLIRQ_BIT_PIN_ROUTE 0
`define SLIRQ_BIT_LINK_PAGE 0
`define SLIRQ_RST_BYTE 8'h00
`define SLIRQ_RST_BIT 1'b0
`endif

// ---- verilog/slirq_cfg_compare.v ----
// lane-0 configuration octet comparator for one link
`timescale 1ns/1ps
`default_nettype none
`include "slirq_defines.vh"
module slirq_cfg_compare (
  input wire clk_sys,
  input wire sys_rst,
  input wire oct_valid,
  input wire [3:0] oct_index,
  input wire [7:0] oct_data,
  input wire [7:0] exp_data,
  input wire cfg_done,
  output reg mismatch_pulse
);
  reg diff_reg;
  reg diff_next;
  ////////////////////////////////////////////////////////////////////////
  // every octet counts, checksum octet included
  always @* begin
    diff_next = diff_reg;
    if (oct_valid && oct_index == 4'h0) begin
      diff_next = (oct_data != exp_data);
    end else if (oct_valid && oct_data != exp_data) begin
      diff_next = 1'b1;
    end
  end
  // verdict lands once, after the last octet
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      diff_reg <= 1'b0;
      mismatch_pulse <= 1'b0;
    end else begin
      diff_reg <= cfg_done ? 1'b0 : diff_next;
      mismatch_pulse <= cfg_done & diff_next;
    end
  end
endmodule
`default_nettype wire

// ---- verification/slirq_checker.sv ----
// port-level assertions for the link interrupt router
`timescale 1ns/1ps
`default_nettype none
module slirq_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] link_events,
  input wire logic [1:0] cks_sent_valid,
  input wire logic [1:0] cfg_done,
  input wire logic interrupt_pin_a,
  input wire logic interrupt_pin_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // either pin high means some flag is latched
  wire logic any_pin = interrupt_pin_a | interrupt_pin_b;
  // a route write followed by a cycle with no further route write
  sequence s_route(bit v);
    reg_wr && reg_addr == 12'h4bc && reg_wdata[0] == v ##1 !(reg_wr && reg_addr == 12'h4bc);
  endsequence
  property p_one_pin; !(interrupt_pin_a && interrupt_pin_b); endproperty
  a_one_pin: assert property (p_one_pin) else $error("both pins high");
  property p_route_b; s_route(1) ##1 any_pin |-> !interrupt_pin_a; endproperty
  a_route_b: assert property (p_route_b) else $error("pin a used while routed to b");
  property p_route_a; s_route(0) ##1 any_pin |-> !interrupt_pin_b; endproperty
  a_route_a: assert property (p_route_a) else $error("pin b used while routed to a");
  // a request only rises from an event two edges back, or a verdict three back
  property p_rise; $rose(any_pin) |-> $past(|link_events || |cks_sent_valid, 2) || $past(|cfg_done, 3); endproperty
  a_rise: assert property (p_rise) else $error("request without cause");
  property p_hold; $fell(any_pin) |-> $past(reg_wr, 2); endproperty
  a_hold: assert property (p_hold) else $error("request dropped without write");
  property p_res_sec; reg_rd && reg_addr == 12'h4bb |=> reg_rdata[7:1] == 7'h00; endproperty
  a_res_sec: assert property (p_res_sec) else $error("reserved flag bits set");
  property p_res_pin; reg_rd && reg_addr == 12'h4bc |=> reg_rdata[7:1] == 7'h00; endproperty
  a_res_pin: assert property (p_res_pin) else $error("reserved route bits set");
  property p_quiet; $fell(sys_rst) |-> !any_pin; endproperty
  a_quiet: assert property (p_quiet) else $error("pin high after reset");
endmodule
bind slirq_router slirq_checker slirq_checker_inst (.*);
`default_nettype wire

// ---- verification/slirq_host_model.sv ----
// host side: notes which request pin it was ever called on
`timescale 1ns/1ps
`default_nettype none
module slirq_host_model (
  input wire logic clk_sys,
  input wire logic interrupt_pin_a,
  input wire logic interrupt_pin_b,
  output var logic [1:0] irq_seen
);
  initial irq_seen = 2'b00;
  // sticky so a short request is not missed
  always @(posedge clk_sys) irq_seen <= irq_seen | {interrupt_pin_b, interrupt_pin_a};
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the link interrupt router
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, interrupt_pin_a, interrupt_pin_b;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, en, ev;
  logic [15:0] link_events = 0, cfg_oct_data = 0, cks_sent = 0, cks_calc = 0;
  logic [1:0] cfg_oct_valid = 0, cfg_done = 0, cks_sent_valid = 0, irq_seen;
  logic [3:0] cfg_oct_index = 0;
  logic [31:0] seed = 32'h6a80;
  logic [7:0] ex [14];
  logic [83:0] rst_addr = {12'h123, 12'h4bc, 12'h4bb, 12'h4ba, 12'h4b9, 12'h4b8, 12'h300};
  integer miscompares = 0, tests_run = 0, l, i, n;
  always #25 clk_sys = ~clk_sys;
  slirq_router slirq_router_inst (.*);
  slirq_host_model slirq_host_model_inst (.clk_sys(clk_sys), .interrupt_pin_a(interrupt_pin_a),
    .interrupt_pin_b(interrupt_pin_b), .irq_seen(irq_seen));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // checksum event never comes in on the event bus
  function automatic logic [7:0] want(input logic [7:0] e, input logic [7:0] v);
    return e & v & 8'hfb;
  endfunction
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys) reg_wr = 0;
  endtask
  task chk(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_sys) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys) reg_rd = 0;
    tests_run++;
    if (reg_rdata !== e) begin
      miscompares++;
      $display("unexpected %0t read %h got %h", $time, a, reg_rdata);
    end
  endtask
  task pins(input logic a, input logic b);
    tests_run++;
    if (interrupt_pin_a !== a || interrupt_pin_b !== b) begin
      miscompares++;
      $display("unexpected %0t pins %b%b", $time, interrupt_pin_a, interrupt_pin_b);
    end
  endtask
  task pulse_ev(input integer k, input logic [7:0] v);
    @(negedge clk_sys) link_events = {8'h00, v} << (8 * k);
    @(negedge clk_sys) link_events = 0;
    repeat (2) @(negedge clk_sys);
  endtask
  task complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // stuck-design guard, well beyond the few hundred cycles needed
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_sys);
    sys_rst = 0;
    // reset values, unmapped place reads zero
    for (n = 0; n < 7; n++) chk(rst_addr[12*n +: 12], 8'h00);
    $display("reset test done");
    // event flags except the checksum bit on both link pages, first pass all ones
    for (n = 0; n < 8; n++) begin
      l = n & 1;
      en = n ? rnd() : 8'hff;
      ev = n ? rnd() : 8'hff;
      wr(12'h300, l[7:0]);
      chk(12'h300, l[7:0]);
      wr(12'h4b8, en);
      pulse_ev(l, ev);
      chk(12'h4ba, want(en, ev));
      pins(|want(en, ev), 1'b0);
      wr(12'h4ba, 8'hff);
      chk(12'h4ba, 8'h00);
    end
    $display("event test done");
    wr(12'h300, 8'h00);
    wr(12'h4b8, 8'h04);
    for (n = 0; n < 2; n++) begin
      ev = rnd();
      @(negedge clk_sys) {cks_sent_valid, cks_sent, cks_calc} = {2'b01, 8'h00, ev, 8'h00, ev ^ n[7:0]};
      @(negedge clk_sys) cks_sent_valid = 0;
      chk(12'h4ba, n ? 8'h00 : 8'h04);
      wr(12'h4ba, 8'hff);
    end
    $display("checksum test done");
    wr(12'h4b9, 8'h01);
    for (i = 0; i < 14; i++) begin
      ex[i] = rnd();
      wr(12'h450 + i[11:0], ex[i]);
    end
    // later passes spoil only the checksum octet; the last one runs with the mismatch enable off
    for (n = 0; n < 3; n++) begin
      if (n == 2) begin
        wr(12'h4bb, 8'hff);
        wr(12'h4b9, 8'h00);
      end
      for (i = 0; i < 14; i++) begin
        @(negedge clk_sys) {cfg_oct_valid, cfg_oct_index} = {2'b01, i[3:0]};
        cfg_oct_data = {8'h00, ex[i] ^ {7'h00, n > 0 && i == 13}};
      end
      @(negedge clk_sys) {cfg_oct_valid, cfg_done} = 4'b0001;
      @(negedge clk_sys) cfg_done = 0;
      repeat (2) @(negedge clk_sys);
      chk(12'h4bb, {7'h00, n == 1});
    end
    wr(12'h4bb, 8'hff);
    chk(12'h4bb, 8'h00);
    $display("mismatch test done");
    wr(12'h4b8, 8'h80);
    pulse_ev(0, 8'h80);
    pins(1'b1, 1'b0);
    wr(12'h4bc, 8'hff);
    chk(12'h4bc, 8'h01);
    pins(1'b0, 1'b1);
    wr(12'h4bc, 8'h00);
    chk(12'h4bc, 8'h00);
    pins(1'b1, 1'b0);
    tests_run++;
    if (irq_seen !== 2'b11) begin
      miscompares++;
      $display("unexpected %0t host saw %b", $time, irq_seen);
    end
    $display("route test done");
    complete_run();
  end
endmodule
`default_nettype wire
